// ===== core/dpr_pkg.sv
// What this block does
// R1 - Host reaches every configuration register through the port with 6-bit offsets.
// R2 - Last packet header readable at 0x31..0x34: type, count low, count high, check.
// R3 - Second header set at 0x35..0x38 only in 16-bit gear, four-lane builds.
// R4 - Host sets 0x00 bit 3 to 0 up to 1.5 Gbps, 1 above.
// R5 - Auto power-down bit powers down idle lanes; otherwise they stay powered at LP11.
// R6 - Offset 0x00 bit 1 picks slave or master, bit 0 picks CSI-2 or DSI.
// R7 - Offset 0x02 bit 3 bypasses (0) or enables (1) the lane interface logic.
// R8 - Offset 0x03 bit 0 enables deskew, gating sync flags; upper bits written 010.
// R9 - First lane select: bit 0 at 0x09 bit 3, bit 1 at 0x0A bit 0.
// R10 - 0x0A bits 2:1 set lane count; bit 3 starts the clock settle count.
// R11 - Settle time equals settle count plus one sync clock periods.
// R12 - Host writes reserved bits with their shown values only.
// R13 - Continuous-clock bit lets the clock lane keep its high-speed receive state.
package dpr_pkg;

  localparam int OFFS_W    = 6;
  localparam int DATA_W    = 8;
  localparam int SETTLE_W  = 6;
  localparam int DEF_GEAR  = 8;
  localparam int DEF_LANES = 4;
  localparam int SECOND_GEAR  = 16;
  localparam int SECOND_LANES = 4;

  localparam logic [5:0] OFF_MODE     = 6'h00;
  localparam logic [5:0] OFF_LPCD     = 6'h01;
  localparam logic [5:0] OFF_LANEIF   = 6'h02;
  localparam logic [5:0] OFF_DESKEW   = 6'h03;
  localparam logic [5:0] OFF_MAPLO    = 6'h09;
  localparam logic [5:0] OFF_CNTSET   = 6'h0A;
  localparam logic [5:0] OFF_CSET_MID = 6'h0B;
  localparam logic [5:0] OFF_CSET_HI  = 6'h0C;
  localparam logic [5:0] OFF_DSET_LO  = 6'h0F;
  localparam logic [5:0] OFF_DSET_HI  = 6'h10;
  localparam logic [5:0] OFF_CONTCLK  = 6'h1E;
  localparam logic [5:0] OFF_HDR_TYPE = 6'h31;
  localparam logic [5:0] OFF_HDR_WCL  = 6'h32;
  localparam logic [5:0] OFF_HDR_WCH  = 6'h33;
  localparam logic [5:0] OFF_HDR_ECC  = 6'h34;
  localparam logic [5:0] OFF_SEC_TYPE = 6'h35;
  localparam logic [5:0] OFF_SEC_WCL  = 6'h36;
  localparam logic [5:0] OFF_SEC_WCH  = 6'h37;
  localparam logic [5:0] OFF_SEC_ECC  = 6'h38;
  localparam logic [5:0] OFF_REFTYPE  = 6'h39;

  localparam int BIT_SPEED   = 3;
  localparam int BIT_AUTOPD  = 2;
  localparam int BIT_MASTER  = 1;
  localparam int BIT_DSI     = 0;
  localparam int BIT_LIF_EN  = 3;
  localparam int BIT_DESKEW  = 0;
  localparam int BIT_MAP0    = 3;
  localparam int BIT_MAP1    = 0;
  localparam int BIT_CSET0   = 3;
  localparam int LANES_LSB   = 1;
  localparam int BIT_CSET5   = 0;
  localparam int BIT_CONT    = 0;

  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] lpcd;
    logic [3:0] laneif;
    logic [3:0] deskew;
    logic [3:0] maplo;
    logic [3:0] cntset;
    logic [3:0] cset_mid;
    logic [3:0] cset_hi;
    logic [3:0] dset_lo;
    logic [3:0] dset_hi;
    logic [3:0] contclk;
  } dpr_cfg_s;

  // Settle counts come up at 9 (clock lane) and 6 (data lanes).
  localparam dpr_cfg_s CFG_RST = '{
    mode: 4'h0, lpcd: 4'h4, laneif: 4'h1, deskew: 4'h4, maplo: 4'h0,
    cntset: 4'h8, cset_mid: 4'h4, cset_hi: 4'h0, dset_lo: 4'h8,
    dset_hi: 4'h1, contclk: 4'h0};
  localparam logic [7:0] RST_REFTYPE = 8'h00;

  typedef struct packed {
    logic [7:0]  chan_type;
    logic [15:0] count;
    logic [7:0]  check;
  } dpr_hdr_s;

  typedef struct packed {
    logic                speed_high;
    logic                auto_pd;
    logic                master;
    logic                dsi;
    logic                lane_if_en;
    logic                deskew_en;
    logic [1:0]          first_lane;
    logic [1:0]          num_lanes;
    logic [SETTLE_W-1:0] clk_settle;
    logic [SETTLE_W-1:0] data_settle;
    logic                cont_clk;
    logic [1:0]          lpcd_thr;
    logic [2:0]          lprx_thr;
  } dpr_ctrl_s;

  typedef enum logic {ST_IDLE, ST_SETTLE} dpr_settle_e;

endpackage

// ===== core/dpr_hdr_capture.sv
`timescale 1ns/1ps
module dpr_hdr_capture (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  input  wire logic              hdr_valid,
  input  wire dpr_pkg::dpr_hdr_s hdr_in,
  output dpr_pkg::dpr_hdr_s      hdr_q
);

  dpr_pkg::dpr_hdr_s hdr_ff;
  dpr_pkg::dpr_hdr_s nxt_hdr;

  // The copy is replaced whole so a reader never sees fields of two packets.
  always_comb begin
    nxt_hdr = hdr_ff;
    if (hdr_valid) begin
      nxt_hdr = hdr_in;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hdr_ff <= '0;
    end else if (ce) begin
      hdr_ff <= nxt_hdr;
    end
  end

  assign hdr_q = hdr_ff;

endmodule

// ===== core/dpr_config_regs.sv
`timescale 1ns/1ps
module dpr_config_regs #(
  parameter int GEAR     = dpr_pkg::DEF_GEAR,
  parameter int RX_LANES = dpr_pkg::DEF_LANES
) (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         ce,
  input  wire logic                         cfg_request,
  input  wire logic                         cfg_write,
  input  wire logic [dpr_pkg::OFFS_W-1:0]   cfg_offset,
  input  wire logic [dpr_pkg::DATA_W-1:0]   cfg_wdata,
  output logic                              cfg_ready,
  output logic [dpr_pkg::DATA_W-1:0]        cfg_rdata,
  output logic                              cfg_rdata_valid,
  input  wire logic                         hdr_valid,
  input  wire dpr_pkg::dpr_hdr_s            hdr_in,
  input  wire logic                         hdr2_valid,
  input  wire dpr_pkg::dpr_hdr_s            hdr2_in,
  input  wire logic                         raw_sync_error,
  input  wire logic                         raw_no_sync,
  input  wire logic                         clk_lane_hs,
  input  wire logic                         lane_hs_start,
  output dpr_pkg::dpr_ctrl_s                phy_ctrl,
  output logic [dpr_pkg::DATA_W-1:0]        reference_type,
  output logic [RX_LANES-1:0]               lane_power_down,
  output logic [RX_LANES-1:0]               lane_hold_lp11,
  output logic                              sync_error_flag,
  output logic                              no_sync_flag,
  output logic                              clk_lane_hs_hold,
  output logic                              settle_done
);

  localparam bit HAS_SECOND = (GEAR == dpr_pkg::SECOND_GEAR) &&
                              (RX_LANES == dpr_pkg::SECOND_LANES);

  dpr_pkg::dpr_cfg_s              cfg_ff;
  dpr_pkg::dpr_cfg_s              nxt_cfg;
  logic [dpr_pkg::DATA_W-1:0]     ref_ff;
  logic [dpr_pkg::DATA_W-1:0]     nxt_ref;
  logic [dpr_pkg::DATA_W-1:0]     rdata_ff;
  logic [dpr_pkg::DATA_W-1:0]     nxt_rdata;
  logic                           rvalid_ff;
  logic                           nxt_rvalid;
  dpr_pkg::dpr_hdr_s              hdr1_q;
  dpr_pkg::dpr_hdr_s              hdr2_q;
  logic [RX_LANES-1:0]            pd_ff;
  logic [RX_LANES-1:0]            nxt_pd;
  logic [RX_LANES-1:0]            hold_ff;
  logic [RX_LANES-1:0]            nxt_hold;
  logic                           serr_ff;
  logic                           nxt_serr;
  logic                           nsync_ff;
  logic                           nxt_nsync;
  logic                           hshold_ff;
  logic                           nxt_hshold;
  dpr_pkg::dpr_settle_e           st_ff;
  dpr_pkg::dpr_settle_e           nxt_st;
  logic [dpr_pkg::SETTLE_W-1:0]   cnt_ff;
  logic [dpr_pkg::SETTLE_W-1:0]   nxt_cnt;
  logic [dpr_pkg::SETTLE_W-1:0]   elapsed_ff;
  logic [dpr_pkg::SETTLE_W-1:0]   load_ff;
  logic                           wr_en;
  logic                           rd_en;

  assign cfg_ready = ce;
  assign wr_en     = cfg_request && cfg_write;
  assign rd_en     = cfg_request && !cfg_write;

  // Header copies from the packet parser.
  dpr_hdr_capture u_hdr1 (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .hdr_valid (hdr_valid),
    .hdr_in    (hdr_in),
    .hdr_q     (hdr1_q)
  );

  generate
    if (HAS_SECOND) begin : g_second
      dpr_hdr_capture u_hdr2 (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .hdr_valid (hdr2_valid),
        .hdr_in    (hdr2_in),
        .hdr_q     (hdr2_q)
      );
    end else begin : g_no_second
      assign hdr2_q = '0; // R3
    end
  endgenerate

  // Writes land on the edge that takes the request. Reserved bits are kept
  // as written because the host is trusted to write their fixed values.
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_ref = ref_ff;
    if (wr_en) begin
      case (cfg_offset) // R1 R12
        dpr_pkg::OFF_MODE:     nxt_cfg.mode     = cfg_wdata[3:0];
        dpr_pkg::OFF_LPCD:     nxt_cfg.lpcd     = cfg_wdata[3:0];
        dpr_pkg::OFF_LANEIF:   nxt_cfg.laneif   = cfg_wdata[3:0];
        dpr_pkg::OFF_DESKEW:   nxt_cfg.deskew   = cfg_wdata[3:0];
        dpr_pkg::OFF_MAPLO:    nxt_cfg.maplo    = cfg_wdata[3:0];
        dpr_pkg::OFF_CNTSET:   nxt_cfg.cntset   = cfg_wdata[3:0];
        dpr_pkg::OFF_CSET_MID: nxt_cfg.cset_mid = cfg_wdata[3:0];
        dpr_pkg::OFF_CSET_HI:  nxt_cfg.cset_hi  = cfg_wdata[3:0];
        dpr_pkg::OFF_DSET_LO:  nxt_cfg.dset_lo  = cfg_wdata[3:0];
        dpr_pkg::OFF_DSET_HI:  nxt_cfg.dset_hi  = cfg_wdata[3:0];
        dpr_pkg::OFF_CONTCLK:  nxt_cfg.contclk  = cfg_wdata[3:0];
        dpr_pkg::OFF_REFTYPE:  nxt_ref          = cfg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ff <= dpr_pkg::CFG_RST;
      ref_ff <= dpr_pkg::RST_REFTYPE;
    end else if (ce) begin
      cfg_ff <= nxt_cfg;
      ref_ff <= nxt_ref;
    end
  end

  // Read data is registered; the reference type is write-only and reads zero,
  // as does any offset without a register behind it.
  always_comb begin
    nxt_rdata  = rdata_ff;
    nxt_rvalid = rd_en;
    if (rd_en) begin
      case (cfg_offset) // R1
        dpr_pkg::OFF_MODE:     nxt_rdata = {4'h0, cfg_ff.mode};
        dpr_pkg::OFF_LPCD:     nxt_rdata = {4'h0, cfg_ff.lpcd};
        dpr_pkg::OFF_LANEIF:   nxt_rdata = {4'h0, cfg_ff.laneif};
        dpr_pkg::OFF_DESKEW:   nxt_rdata = {4'h0, cfg_ff.deskew};
        dpr_pkg::OFF_MAPLO:    nxt_rdata = {4'h0, cfg_ff.maplo};
        dpr_pkg::OFF_CNTSET:   nxt_rdata = {4'h0, cfg_ff.cntset};
        dpr_pkg::OFF_CSET_MID: nxt_rdata = {4'h0, cfg_ff.cset_mid};
        dpr_pkg::OFF_CSET_HI:  nxt_rdata = {4'h0, cfg_ff.cset_hi};
        dpr_pkg::OFF_DSET_LO:  nxt_rdata = {4'h0, cfg_ff.dset_lo};
        dpr_pkg::OFF_DSET_HI:  nxt_rdata = {4'h0, cfg_ff.dset_hi};
        dpr_pkg::OFF_CONTCLK:  nxt_rdata = {4'h0, cfg_ff.contclk};
        dpr_pkg::OFF_HDR_TYPE: nxt_rdata = hdr1_q.chan_type; // R2
        dpr_pkg::OFF_HDR_WCL:  nxt_rdata = hdr1_q.count[7:0]; // R2
        dpr_pkg::OFF_HDR_WCH:  nxt_rdata = hdr1_q.count[15:8]; // R2
        dpr_pkg::OFF_HDR_ECC:  nxt_rdata = hdr1_q.check; // R2
        dpr_pkg::OFF_SEC_TYPE: nxt_rdata = hdr2_q.chan_type; // R3
        dpr_pkg::OFF_SEC_WCL:  nxt_rdata = hdr2_q.count[7:0]; // R3
        dpr_pkg::OFF_SEC_WCH:  nxt_rdata = hdr2_q.count[15:8]; // R3
        dpr_pkg::OFF_SEC_ECC:  nxt_rdata = hdr2_q.check; // R3
        default:               nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else if (ce) begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign cfg_rdata       = rdata_ff;
  assign cfg_rdata_valid = rvalid_ff;

  // Field view for the hard PHY, taken straight from the stored nibbles.
  always_comb begin
    phy_ctrl             = '0;
    phy_ctrl.speed_high  = cfg_ff.mode[dpr_pkg::BIT_SPEED]; // R4
    phy_ctrl.auto_pd     = cfg_ff.mode[dpr_pkg::BIT_AUTOPD];
    phy_ctrl.master      = cfg_ff.mode[dpr_pkg::BIT_MASTER]; // R6
    phy_ctrl.dsi         = cfg_ff.mode[dpr_pkg::BIT_DSI]; // R6
    phy_ctrl.lane_if_en  = cfg_ff.laneif[dpr_pkg::BIT_LIF_EN]; // R7
    phy_ctrl.deskew_en   = cfg_ff.deskew[dpr_pkg::BIT_DESKEW]; // R8
    phy_ctrl.first_lane  = {cfg_ff.cntset[dpr_pkg::BIT_MAP1],
                            cfg_ff.maplo[dpr_pkg::BIT_MAP0]}; // R9
    phy_ctrl.num_lanes   = cfg_ff.cntset[dpr_pkg::LANES_LSB +: 2]; // R10
    phy_ctrl.clk_settle  = {cfg_ff.cset_hi[dpr_pkg::BIT_CSET5], cfg_ff.cset_mid,
                            cfg_ff.cntset[dpr_pkg::BIT_CSET0]}; // R10
    phy_ctrl.data_settle = {cfg_ff.dset_hi, cfg_ff.dset_lo[3:2]};
    phy_ctrl.cont_clk    = cfg_ff.contclk[dpr_pkg::BIT_CONT];
    phy_ctrl.lpcd_thr    = cfg_ff.lpcd[3:2];
    phy_ctrl.lprx_thr    = cfg_ff.laneif[2:0];
  end

  assign reference_type = ref_ff;

  // Lane i is active when its index does not exceed the lane count field.
  always_comb begin
    nxt_pd   = '0;
    nxt_hold = '0;
    for (int i = 0; i < RX_LANES; i++) begin
      if (i > int'(phy_ctrl.num_lanes)) begin
        nxt_pd[i]   = phy_ctrl.auto_pd; // R5
        nxt_hold[i] = !phy_ctrl.auto_pd; // R5
      end
    end
    // Sync indications only pass while deskew is enabled.
    nxt_serr   = raw_sync_error && phy_ctrl.deskew_en; // R8
    nxt_nsync  = raw_no_sync && phy_ctrl.deskew_en; // R8
    nxt_hshold = clk_lane_hs && phy_ctrl.cont_clk; // R13
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pd_ff     <= '0;
      hold_ff   <= '0;
      serr_ff   <= 1'b0;
      nsync_ff  <= 1'b0;
      hshold_ff <= 1'b0;
    end else if (ce) begin
      pd_ff     <= nxt_pd;
      hold_ff   <= nxt_hold;
      serr_ff   <= nxt_serr;
      nsync_ff  <= nxt_nsync;
      hshold_ff <= nxt_hshold;
    end
  end

  assign lane_power_down  = pd_ff;
  assign lane_hold_lp11   = hold_ff;
  assign sync_error_flag  = serr_ff;
  assign no_sync_flag     = nsync_ff;
  assign clk_lane_hs_hold = hshold_ff;

  // Settle timer for the clock lane: count+1 cycles of this clock, which is
  // the sync clock. A start during a running settle is ignored.
  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      dpr_pkg::ST_IDLE: begin
        if (lane_hs_start) begin
          nxt_st  = dpr_pkg::ST_SETTLE;
          nxt_cnt = phy_ctrl.clk_settle; // R11
        end
      end
      dpr_pkg::ST_SETTLE: begin
        if (cnt_ff == '0) begin
          nxt_st = dpr_pkg::ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 6'h01; // R11
        end
      end
      default: nxt_st = dpr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff  <= dpr_pkg::ST_IDLE;
      cnt_ff <= '0;
    end else if (ce) begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  assign settle_done = ce && (st_ff == dpr_pkg::ST_SETTLE) && (cnt_ff == '0);

  // Helper for checking: cycles already spent settling and the loaded count.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      elapsed_ff <= '0;
      load_ff    <= '0;
    end else if (ce) begin
      if (st_ff == dpr_pkg::ST_IDLE) begin
        elapsed_ff <= '0;
        load_ff    <= nxt_cnt;
      end else begin
        elapsed_ff <= elapsed_ff + 6'h01;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_read_latency: assert property (rd_en && ce |=> cfg_rdata_valid) // R1
    else $error("read answer missing one cycle after request");
  a_hdr_readback: assert property ( // R2
    rd_en && ce && cfg_offset == dpr_pkg::OFF_HDR_WCH
    |=> cfg_rdata == $past(hdr1_q.count[15:8]))
    else $error("header count high readback wrong");
  a_second_absent: assert property ( // R3
    !HAS_SECOND && rd_en && ce && cfg_offset == dpr_pkg::OFF_SEC_TYPE
    |=> cfg_rdata == 8'h00)
    else $error("second header readable in a build without it");
  a_pd_hold_excl: assert property ( // R5
    ce ##1 ce |-> (lane_power_down == '0) || (lane_hold_lp11 == '0))
    else $error("lane both powered down and held at LP11");
  a_role_write: assert property ( // R6
    wr_en && ce && cfg_offset == dpr_pkg::OFF_MODE
    |=> phy_ctrl.master == $past(cfg_wdata[1]) && phy_ctrl.dsi == $past(cfg_wdata[0]))
    else $error("role or application bit not taken");
  a_lif_write: assert property ( // R7
    wr_en && ce && cfg_offset == dpr_pkg::OFF_LANEIF
    |=> phy_ctrl.lane_if_en == $past(cfg_wdata[3]))
    else $error("lane interface enable not taken");
  a_deskew_gate: assert property ( // R8
    ce && !phy_ctrl.deskew_en |=> !sync_error_flag && !no_sync_flag)
    else $error("sync flag passed with deskew disabled");
  a_lane_select: assert property ( // R9
    wr_en && ce && cfg_offset == dpr_pkg::OFF_CNTSET
    |=> phy_ctrl.first_lane[1] == $past(cfg_wdata[0]) &&
        phy_ctrl.num_lanes == $past(cfg_wdata[2:1]))
    else $error("first lane or lane count bits misplaced");
  a_settle_time: assert property (settle_done |-> elapsed_ff == load_ff) // R11
    else $error("settle did not last count plus one cycles");
  a_cont_clk: assert property (ce && !phy_ctrl.cont_clk |=> !clk_lane_hs_hold) // R13
    else $error("clock lane hold without continuous clock option");

endmodule

// ===== testbench/dpr_host_model.sv
`timescale 1ns/1ps
module dpr_host_model (
  input  wire logic       clk,
  input  wire logic       cfg_ready,
  input  wire logic [7:0] cfg_rdata,
  input  wire logic       cfg_rdata_valid,
  output logic            cfg_request,
  output logic            cfg_write,
  output logic [5:0]      cfg_offset,
  output logic [7:0]      cfg_wdata
);

  initial begin
    cfg_request = 1'b0;
    cfg_write   = 1'b0;
    cfg_offset  = 6'h00;
    cfg_wdata   = 8'h00;
  end

  // Reserved bits leave with their fixed pattern, whatever the caller asked for, except 0x09 bits 2:0, which pass through as given.
  function automatic logic [7:0] fix_rsv(input logic [5:0] off, input logic [7:0] d);
    case (off)
      6'h01, 6'h0F: fix_rsv = {4'h0, d[3:2], 2'b00};
      6'h03:        fix_rsv = {4'h0, 3'b010, d[0]};
      6'h0C, 6'h1E: fix_rsv = {7'h00, d[0]};
      6'h39:        fix_rsv = d;
      default:      fix_rsv = {4'h0, d[3:0]};
    endcase
  endfunction

  // Request is held until an edge that finds the port ready; it is left raised so
  // that back-to-back calls need no gap, and idle lowers it.
  task automatic xfer(input logic wr, input logic [5:0] off, input logic [7:0] d,
                      output logic [7:0] q, output logic v);
    cfg_request = 1'b1;
    cfg_write   = wr;
    cfg_offset  = off;
    cfg_wdata   = wr ? fix_rsv(off, d) : 8'h00;
    @(posedge clk);
    while (cfg_ready !== 1'b1) @(posedge clk);
    #1;
    q = cfg_rdata;
    v = cfg_rdata_valid;
  endtask

  task automatic idle();
    cfg_request = 1'b0;
  endtask

  // The speed bit follows the lane rate the host intends to run.
  task automatic set_mode(input int rate_mbps, input logic apd, input logic mst, input logic dsi);
    logic [7:0] q;
    logic       v;
    xfer(1'b1, 6'h00, {4'h0, rate_mbps > 1500, apd, mst, dsi}, q, v);
  endtask

endmodule

// ===== testbench/dpr_config_regs_bench.sv
`timescale 1ns/1ps
module dpr_config_regs_bench;
  logic               clk = 1'b0;
  logic               nrst = 1'b0;
  logic               ce = 1'b1;
  logic               cfg_request;
  logic               cfg_write;
  logic [5:0]         cfg_offset;
  logic [7:0]         cfg_wdata;
  logic               cfg_ready;
  logic [7:0]         cfg_rdata;
  logic               cfg_rdata_valid;
  logic               hdr_valid = 1'b0;
  dpr_pkg::dpr_hdr_s  hdr_in = '0;
  logic               hdr2_valid = 1'b0;
  dpr_pkg::dpr_hdr_s  hdr2_in = '0;
  logic               raw_sync_error = 1'b0;
  logic               raw_no_sync = 1'b0;
  logic               clk_lane_hs = 1'b0;
  logic               lane_hs_start = 1'b0;
  dpr_pkg::dpr_ctrl_s phy_ctrl;
  logic [7:0]         reference_type;
  logic [3:0]         lane_power_down;
  logic [3:0]         lane_hold_lp11;
  logic               sync_error_flag;
  logic               no_sync_flag;
  logic               clk_lane_hs_hold;
  logic               settle_done;
  logic [7:0]         narrow_rdata;
  int                 errors = 0;
  int                 n_checks = 0;
  int                 cyc = 0;

  always #2 clk = ~clk;

  dpr_config_regs #(.GEAR(16), .RX_LANES(4)) i_dpr_config_regs (
    .clk(clk), .nrst(nrst), .ce(ce), .cfg_request(cfg_request), .cfg_write(cfg_write),
    .cfg_offset(cfg_offset), .cfg_wdata(cfg_wdata), .cfg_ready(cfg_ready),
    .cfg_rdata(cfg_rdata), .cfg_rdata_valid(cfg_rdata_valid), .hdr_valid(hdr_valid),
    .hdr_in(hdr_in), .hdr2_valid(hdr2_valid), .hdr2_in(hdr2_in),
    .raw_sync_error(raw_sync_error), .raw_no_sync(raw_no_sync), .clk_lane_hs(clk_lane_hs),
    .lane_hs_start(lane_hs_start), .phy_ctrl(phy_ctrl), .reference_type(reference_type),
    .lane_power_down(lane_power_down), .lane_hold_lp11(lane_hold_lp11),
    .sync_error_flag(sync_error_flag), .no_sync_flag(no_sync_flag),
    .clk_lane_hs_hold(clk_lane_hs_hold), .settle_done(settle_done));

  // A build without the second header set shares the port and must answer zero there.
  dpr_config_regs i_dpr_config_regs_narrow (
    .clk(clk), .nrst(nrst), .ce(ce), .cfg_request(cfg_request), .cfg_write(cfg_write),
    .cfg_offset(cfg_offset), .cfg_wdata(cfg_wdata), .cfg_ready(), .cfg_rdata(narrow_rdata),
    .cfg_rdata_valid(), .hdr_valid(hdr_valid), .hdr_in(hdr_in), .hdr2_valid(hdr2_valid),
    .hdr2_in(hdr2_in), .raw_sync_error(raw_sync_error), .raw_no_sync(raw_no_sync),
    .clk_lane_hs(clk_lane_hs), .lane_hs_start(lane_hs_start), .phy_ctrl(), .reference_type(),
    .lane_power_down(), .lane_hold_lp11(), .sync_error_flag(), .no_sync_flag(),
    .clk_lane_hs_hold(), .settle_done());

  dpr_host_model i_dpr_host_model (
    .clk(clk), .cfg_ready(cfg_ready), .cfg_rdata(cfg_rdata),
    .cfg_rdata_valid(cfg_rdata_valid), .cfg_request(cfg_request), .cfg_write(cfg_write),
    .cfg_offset(cfg_offset), .cfg_wdata(cfg_wdata));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hang counts against the run and still reaches the verdict.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors = errors + 1;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] off, input logic [7:0] d);
    logic [7:0] q;
    logic       v;
    i_dpr_host_model.xfer(1'b1, off, d, q, v);
  endtask

  task automatic rd(input logic [5:0] off, input logic [7:0] exp);
    logic [7:0] q;
    logic       v;
    i_dpr_host_model.xfer(1'b0, off, 8'h00, q, v);
    chk({31'h0, v}, 32'h1);
    chk({24'h0, q}, {24'h0, exp});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  logic [5:0] offs [11] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0F,
                            6'h10, 6'h1E};
  logic [7:0] rstv [11] = '{8'h0, 8'h4, 8'h1, 8'h4, 8'h0, 8'h8, 8'h4, 8'h0, 8'h8, 8'h1, 8'h0};
  int         k;

  initial begin
    step(4);
    nrst = 1'b1;
    for (int i = 0; i < 11; i++) rd(offs[i], rstv[i]);
    chk(phy_ctrl.clk_settle, 32'h9);
    chk(phy_ctrl.data_settle, 32'h6);
    for (int m = 0; m < 16; m++) begin
      i_dpr_host_model.set_mode(m[3] ? 2000 : 1000, m[2], m[1], m[0]);
      rd(6'h00, m[7:0]);
      chk({phy_ctrl.speed_high, phy_ctrl.auto_pd, phy_ctrl.master, phy_ctrl.dsi}, m);
    end
    for (int a = 0; a < 2; a++) begin
      for (int n = 0; n < 4; n++) begin
        wr(6'h00, {5'h0, a[0], 2'b00});
        wr(6'h0A, {4'h0, 1'b1, n[1:0], 1'b0});
        i_dpr_host_model.idle();
        step(2);
        chk(phy_ctrl.num_lanes, n);
        for (int i = 0; i < 4; i++) begin
          chk(lane_power_down[i], (i > n) ? a : 0);
          chk(lane_hold_lp11[i], (i > n) ? !a : 0);
        end
      end
    end
    wr(6'h02, 8'h9);
    chk({phy_ctrl.lane_if_en, phy_ctrl.lprx_thr}, 32'h9);
    wr(6'h02, 8'h1);
    chk(phy_ctrl.lane_if_en, 32'h0);
    raw_sync_error = 1'b1;
    raw_no_sync = 1'b1;
    wr(6'h03, 8'h1);
    rd(6'h03, 8'h5);
    i_dpr_host_model.idle();
    step(2);
    chk({sync_error_flag, no_sync_flag}, 32'h3);
    wr(6'h03, 8'h0);
    i_dpr_host_model.idle();
    step(2);
    chk({sync_error_flag, no_sync_flag}, 32'h0);
    wr(6'h09, 8'h8);
    wr(6'h0A, 8'hF);
    chk(phy_ctrl.first_lane, 32'h3);
    wr(6'h0A, 8'h9);
    wr(6'h09, 8'h0);
    chk(phy_ctrl.first_lane, 32'h2);
    wr(6'h0B, 8'h2);
    wr(6'h0C, 8'h0);
    wr(6'h0F, 8'hF);
    wr(6'h10, 8'h2);
    rd(6'h0F, 8'hC);
    i_dpr_host_model.idle();
    chk(phy_ctrl.clk_settle, 32'h5);
    chk(phy_ctrl.data_settle, 32'hB);
    step(1);
    lane_hs_start = 1'b1;
    step(1);
    lane_hs_start = 1'b0;
    k = 0;
    while (settle_done !== 1'b1 && k < 100) begin
      step(1);
      k = k + 1;
    end
    chk(k, 5);
    step(1);
    chk(settle_done, 32'h0);
    clk_lane_hs = 1'b1;
    wr(6'h1E, 8'h1);
    i_dpr_host_model.idle();
    step(2);
    chk(clk_lane_hs_hold, 32'h1);
    wr(6'h1E, 8'h0);
    i_dpr_host_model.idle();
    step(2);
    chk(clk_lane_hs_hold, 32'h0);
    hdr_in = '{chan_type: 8'h2B, count: 16'hA512, check: 8'h3C};
    hdr2_in = '{chan_type: 8'hC1, count: 16'h0F7E, check: 8'h96};
    hdr_valid = 1'b1;
    hdr2_valid = 1'b1;
    step(1);
    hdr_valid = 1'b0;
    hdr2_valid = 1'b0;
    rd(6'h31, 8'h2B);
    chk({24'h0, narrow_rdata}, 32'h2B);
    rd(6'h32, 8'h12);
    rd(6'h33, 8'hA5);
    rd(6'h34, 8'h3C);
    rd(6'h35, 8'hC1);
    chk({24'h0, narrow_rdata}, 32'h0);
    rd(6'h36, 8'h7E);
    rd(6'h37, 8'h0F);
    rd(6'h38, 8'h96);
    chk({24'h0, narrow_rdata}, 32'h0);
    // With the enable low a header strobe must be lost and the port not ready.
    ce = 1'b0;
    hdr_in.chan_type = 8'h55;
    hdr_valid = 1'b1;
    step(1);
    chk({31'h0, cfg_ready}, 32'h0);
    hdr_valid = 1'b0;
    ce = 1'b1;
    rd(6'h31, 8'h2B);
    wr(6'h31, 8'hFF);
    rd(6'h31, 8'h2B);
    wr(6'h39, 8'hA5);
    chk(reference_type, 32'hA5);
    rd(6'h39, 8'h00);
    rd(6'h3F, 8'h00);
    i_dpr_host_model.idle();
    step(2);
    give_verdict();
  end
endmodule
